// File: rtl/eep_ctrl.sv
// Summary of operation
// - Extra-column select disables user EPROM, uses address 11:5; special modes only.
// - Extra-row select disables user EPROM, uses address 5:0; special modes only.
// - EPROM voltage enable always readable, writable only while EPROM latch is set.
// - EEPROM decodes at D80-FFF in the page chosen by map position, reset 0.
// - Map register written once in normal modes, freely in special; low nibble zero.
// - Erased EEPROM bytes read back as all ones.
// - While EEPROM latch is set the array leaves the CPU memory map.
// - Byte and row bits choose bulk, 16-byte row or single byte erase.
// - Erase bit selects erase mode, else read or program mode.
// - EEPROM latch bit switches path between normal reads and latching.
// - Program voltage is on exactly while the EEPROM voltage enable is one.
// - Low-voltage flag read-only, needs enable and low supply, blocks programming.
// - Protect bits reset to one, clear once in 64 cycles or in special.
// - Bulk protect refuses bulk and row erase.
// - Configuration protect blocks programming and erasing the configuration byte.
// - Five protect bits each guard one EEPROM region against program, byte or row erase.
// - Configuration reads return latches loaded at reset; unused bits read one.
// - Configuration changes only by programming in normal, direct writes in special.
// - Configuration byte uses the array procedure and erases to ones.
module eep_ctrl #(
	parameter logic [7:0] CFG_USED = 8'h0f
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  special_mode_flag,
	input  wire logic                  low_supply_det,
	input  eep_pkg::eep_apb_req_s      apb,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	input  eep_pkg::eep_cpu_req_s      cpu,
	output logic                       cpu_sel,
	output logic [7:0]                 cpu_rdata,
	output logic                       eeprom_hv_on,
	output eep_pkg::eep_eprom_s        eprom,
	output logic [7:0]                 config_out
);
	import eep_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  eprom_program_control;
		logic [7:0]  eeprom_program_control;
		logic [7:0]  eeprom_block_protect;
		logic [7:0]  map;
		logic [7:0]  cfg;
		logic [6:0]  bp_cnt;
		logic        bp_used;
		logic        map_used;
		logic        cfg_load;
		logic        lv_s1;
		logic        lv_s2;
		logic        lat_valid;
		logic        lat_cfg;
		logic [9:0]  lat_idx;
		logic [7:0]  lat_data;
		logic [11:0] ep_addr;
		logic [31:0] prdata;
		logic [7:0]  cpu_rdata;
	} eep_state_s;

	localparam eep_state_s ST_RST = '{
		eeprom_block_protect:    EEP_EEPROM_BLOCK_PROTECT_RST,
		cfg:      EEP_CFG_RST,
		cfg_load: 1'b1,
		default:  '0
	};

	eep_state_s st;
	eep_state_s next_st;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	logic [7:0]  reg_idx;
	logic        mapped;
	logic        acc;
	logic        wr_acc;
	logic        sp;
	logic        low_voltage_inhibit_flag;
	logic [11:0] cpu_ofs;
	logic        in_eep;
	logic [9:0]  cpu_idx;
	logic [7:0]  arr_rd;
	logic [7:0]  cfg_cell;
	logic [7:0]  wd;
	logic        bp_clear_ok;
	logic        go;
	logic        erase_mode;
	eep_ext_e    ext;
	logic        blocked;
	eep_op_s     op;

	assign sp = special_mode_flag;
	assign reg_idx = apb.paddr[9:2];
	assign wd = apb.pwdata[7:0];
	assign mapped = (apb.paddr[1:0] == 2'h0) && (apb.paddr[11:10] == 2'h0) &&
		(reg_idx == EEP_IDX_EPROM_CTL || reg_idx == EEP_IDX_EEPROM_CTL ||
		 reg_idx == EEP_IDX_BLOCK_PROT || reg_idx == EEP_IDX_MAP_POS ||
		 reg_idx == EEP_IDX_SYS_CFG);
	assign acc = apb.psel && apb.penable;
	assign wr_acc = acc && apb.pwrite && mapped;
	assign pready = acc;
	assign pslverr = acc && !mapped;

	assign low_voltage_inhibit_flag = st.eeprom_block_protect[BP_LOW_VOLTAGE_PROTECT_EN] && st.lv_s2;

	// Window position inside the page picked by the map register.
	assign cpu_ofs = cpu.addr[11:0];
	assign in_eep = (cpu.addr[15:12] == st.map[7:4]) && (cpu_ofs >= EEP_BASE_OFS) &&
		st.cfg[CFG_PRESENT];
	assign cpu_idx = 10'(cpu_ofs - EEP_BASE_OFS);
	assign cpu_sel = in_eep && !st.eeprom_program_control[PP_LAT];

	function automatic logic [7:0] rd_val(input logic [7:0] idx, input eep_state_s s,
		input logic special, input logic lvi);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			EEP_IDX_EPROM_CTL: begin
				v[EP_MBE] = s.eprom_program_control[EP_MBE] && special;
				v[EP_LAT] = s.eprom_program_control[EP_LAT];
				v[EP_XCOL] = s.eprom_program_control[EP_XCOL] && special;
				v[EP_XROW] = s.eprom_program_control[EP_XROW] && special;
				v[EP_PGM] = s.eprom_program_control[EP_PGM];
			end
			EEP_IDX_EEPROM_CTL: begin
				v = s.eeprom_program_control & PP_WR_MASK;
				v[PP_LVI] = lvi;
			end
			EEP_IDX_BLOCK_PROT: v = s.eeprom_block_protect;
			EEP_IDX_MAP_POS: v = {s.map[7:4], EEP_MAP_LOW};
			EEP_IDX_SYS_CFG: v = s.cfg | ~CFG_USED;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Set when the latched target lies in a protected region.
	function automatic logic region_prot(input logic [9:0] idx, input logic [7:0] bp);
		logic [11:0] o;
		o = 12'(idx) + EEP_BASE_OFS;
		if (o >= EEP_REG_F80) begin
			return bp[BP_UPPER];
		end else if (o >= EEP_REG_E60) begin
			return bp[3];
		end else if (o >= EEP_REG_DE0) begin
			return bp[2];
		end else if (o >= EEP_REG_DA0) begin
			return bp[1];
		end
		return bp[0];
	endfunction

	// ----------------------------------------------------------------
	// Program and erase
	// ----------------------------------------------------------------
	assign erase_mode = st.eeprom_program_control[PP_ERASE];
	assign ext = st.eeprom_program_control[PP_BYTE] ? EXT_BYTE :
		(st.eeprom_program_control[PP_ROW] ? EXT_ROW : EXT_BULK);
	// The cells are driven for as long as the voltage is on; both operations
	// are idempotent, so no pulse timer is needed here.
	assign go = st.eeprom_program_control[PP_PGM] && st.eeprom_program_control[PP_LAT] && st.lat_valid && !low_voltage_inhibit_flag;

	always_comb begin
		blocked = 1'b0;
		if (st.lat_cfg) begin
			blocked = st.eeprom_block_protect[BP_CFG];
		end else if (erase_mode && ext != EXT_BYTE) begin
			blocked = st.eeprom_block_protect[BP_BULK];
			if (ext == EXT_ROW) begin
				blocked = blocked || region_prot(st.lat_idx, st.eeprom_block_protect);
			end
		end else begin
			blocked = region_prot(st.lat_idx, st.eeprom_block_protect);
		end
	end

	always_comb begin
		op.prog = go && !erase_mode && !blocked;
		op.erase = go && erase_mode && !blocked;
		op.ext = ext;
		op.cfg = st.lat_cfg;
		op.idx = st.lat_idx;
		op.data = st.lat_data;
	end

	eep_array #(
		.BYTES (EEP_BYTES)
	) u_array (
		.clk      (clk),
		.op       (op),
		.rd_idx   (cpu_idx),
		.rd_data  (arr_rd),
		.cfg_data (cfg_cell)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		bp_clear_ok = sp || (st.bp_cnt < EEP_BP_WINDOW && !st.bp_used);

		next_st.lv_s1 = low_supply_det;
		next_st.lv_s2 = st.lv_s1;
		if (st.bp_cnt < EEP_BP_WINDOW) begin
			next_st.bp_cnt = st.bp_cnt + 7'h01;
		end
		if (st.cfg_load) begin
			next_st.cfg = cfg_cell;
			next_st.cfg_load = 1'b0;
		end

		if (apb.psel && !apb.penable) begin
			next_st.prdata = {24'h0, rd_val(reg_idx, st, sp, low_voltage_inhibit_flag)};
		end

		if (wr_acc) begin
			case (reg_idx)
				EEP_IDX_EPROM_CTL: begin
					if (sp) begin
						next_st.eprom_program_control[EP_MBE] = wd[EP_MBE];
						next_st.eprom_program_control[EP_XCOL] = wd[EP_XCOL];
						next_st.eprom_program_control[EP_XROW] = wd[EP_XROW];
					end
					if (!st.eprom_program_control[EP_PGM]) begin
						next_st.eprom_program_control[EP_LAT] = wd[EP_LAT];
					end
					if (st.eprom_program_control[EP_LAT]) begin
						next_st.eprom_program_control[EP_PGM] = wd[EP_PGM];
					end
				end
				EEP_IDX_EEPROM_CTL: begin
					next_st.eeprom_program_control = wd & PP_WR_MASK;
				end
				EEP_IDX_BLOCK_PROT: begin
					next_st.eeprom_block_protect = bp_clear_ok ? wd : (st.eeprom_block_protect | wd);
					if (!sp && st.bp_cnt < EEP_BP_WINDOW) begin
						next_st.bp_used = 1'b1;
					end
				end
				EEP_IDX_MAP_POS: begin
					if (sp || !st.map_used) begin
						next_st.map = {wd[7:4], EEP_MAP_LOW};
					end
					if (!sp) begin
						next_st.map_used = 1'b1;
					end
				end
				EEP_IDX_SYS_CFG: begin
					if (sp) begin
						next_st.cfg = wd;
					end else if (st.eeprom_program_control[PP_LAT] && !st.eeprom_program_control[PP_PGM]) begin
						next_st.lat_valid = 1'b1;
						next_st.lat_cfg = 1'b1;
						next_st.lat_data = wd;
					end
				end
				default: begin
				end
			endcase
		end

		// Address and data are captured only while the latch is set and the
		// voltage is still off, so a running pulse keeps its target.
		if (cpu.wr && in_eep && st.eeprom_program_control[PP_LAT] && !st.eeprom_program_control[PP_PGM]) begin
			next_st.lat_valid = 1'b1;
			next_st.lat_cfg = 1'b0;
			next_st.lat_idx = cpu_idx;
			next_st.lat_data = cpu.wdata;
		end
		if (!st.eeprom_program_control[PP_LAT]) begin
			next_st.lat_valid = 1'b0;
		end

		next_st.cpu_rdata = cpu_sel ? arr_rd : 8'h00;

		if (st.eprom_program_control[EP_XCOL] && sp) begin
			next_st.ep_addr = {cpu.addr[11:5], 5'h00};
		end else if (st.eprom_program_control[EP_XROW] && sp) begin
			next_st.ep_addr = {6'h00, cpu.addr[5:0]};
		end else begin
			next_st.ep_addr = cpu.addr[11:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = st.prdata;
	assign cpu_rdata = st.cpu_rdata;
	assign eeprom_hv_on = st.eeprom_program_control[PP_PGM];
	assign config_out = st.cfg | ~CFG_USED;
	// The EEPROM latch takes the shared path away from the EPROM.
	assign eprom.latch = st.eprom_program_control[EP_LAT] && !st.eeprom_program_control[PP_LAT];
	assign eprom.hv_on = st.eprom_program_control[EP_PGM];
	assign eprom.user_off = sp && (st.eprom_program_control[EP_XCOL] || st.eprom_program_control[EP_XROW]);
	assign eprom.cell_addr = st.ep_addr;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_hv_follows;
		@(posedge clk) disable iff (sys_rst)
		(wr_acc && reg_idx == EEP_IDX_EEPROM_CTL) |=> (eeprom_hv_on == $past(wd[PP_PGM]));
	endproperty
	a_hv_follows: assert property (p_hv_follows) else $error("hv not per write");

	property p_lat_hides;
		@(posedge clk) disable iff (sys_rst)
		st.eeprom_program_control[PP_LAT] |-> !cpu_sel;
	endproperty
	a_lat_hides: assert property (p_lat_hides) else $error("eeprom visible in latch");

	property p_eeprom_block_protect_rst;
		@(posedge clk) $past(sys_rst) |-> st.eeprom_block_protect == EEP_EEPROM_BLOCK_PROTECT_RST;
	endproperty
	a_eeprom_block_protect_rst: assert property (p_eeprom_block_protect_rst) else $error("protect reset wrong");

	property p_eeprom_block_protect_late;
		@(posedge clk) disable iff (sys_rst)
		(!sp && st.bp_cnt == EEP_BP_WINDOW) |=> ((st.eeprom_block_protect & $past(st.eeprom_block_protect)) == $past(st.eeprom_block_protect));
	endproperty
	a_eeprom_block_protect_late: assert property (p_eeprom_block_protect_late) else $error("late protect clear");

	property p_map_low;
		@(posedge clk) disable iff (sys_rst)
		(apb.psel && !apb.penable && reg_idx == EEP_IDX_MAP_POS) |=> prdata[3:0] == 4'h0;
	endproperty
	a_map_low: assert property (p_map_low) else $error("map low bits set");

	property p_low_voltage_inhibit_flag;
		@(posedge clk) disable iff (sys_rst)
		(st.lv_s2 && st.eeprom_block_protect[BP_LOW_VOLTAGE_PROTECT_EN]) |-> !op.prog && !op.erase;
	endproperty
	a_low_voltage_inhibit_flag: assert property (p_low_voltage_inhibit_flag) else $error("cells driven at low supply");

	property p_pgm_gate;
		@(posedge clk) disable iff (sys_rst)
		$rose(st.eprom_program_control[EP_PGM]) |-> $past(st.eprom_program_control[EP_LAT], 1);
	endproperty
	a_pgm_gate: assert property (p_pgm_gate) else $error("eprom_prog_voltage_en set without latch");

	property p_xcol_normal;
		@(posedge clk) disable iff (sys_rst)
		(!sp && apb.psel && !apb.penable && reg_idx == EEP_IDX_EPROM_CTL)
			|=> prdata[EP_XCOL] == 1'b0 && prdata[EP_XROW] == 1'b0;
	endproperty
	a_xcol_normal: assert property (p_xcol_normal) else $error("extra select visible");

	property p_bulk_refused;
		@(posedge clk) disable iff (sys_rst)
		(st.eeprom_block_protect[BP_BULK] && !st.lat_cfg && op.ext == EXT_BULK) |-> !op.erase;
	endproperty
	a_bulk_refused: assert property (p_bulk_refused) else $error("bulk erase protected");

	c_program: cover property (@(posedge clk) disable iff (sys_rst) op.prog && !op.cfg);
	c_bulk: cover property (@(posedge clk) disable iff (sys_rst) op.erase && op.ext == EXT_BULK);
	c_unprot: cover property (@(posedge clk) disable iff (sys_rst) $fell(st.eeprom_block_protect[0]));

endmodule

// File: rtl/eep_pkg.sv
package eep_pkg;

	// ----------------------------------------------------------------
	// Register indexes (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] EEP_IDX_EPROM_CTL = 8'h2b;
	localparam logic [7:0] EEP_IDX_EEPROM_CTL = 8'h3b;
	localparam logic [7:0] EEP_IDX_BLOCK_PROT = 8'h35;
	localparam logic [7:0] EEP_IDX_MAP_POS = 8'h37;
	localparam logic [7:0] EEP_IDX_SYS_CFG = 8'h3f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	// EPROM program control.
	localparam int EP_MBE = 7;
	localparam int EP_LAT = 5;
	localparam int EP_XCOL = 4;
	localparam int EP_XROW = 3;
	localparam int EP_PGM = 0;
	// EEPROM program control.
	localparam int PP_LVI = 5;
	localparam int PP_BYTE = 4;
	localparam int PP_ROW = 3;
	localparam int PP_ERASE = 2;
	localparam int PP_LAT = 1;
	localparam int PP_PGM = 0;
	localparam logic [7:0] PP_WR_MASK = 8'h1f;
	// Block protect.
	localparam int BP_BULK = 7;
	localparam int BP_LOW_VOLTAGE_PROTECT_EN = 6;
	localparam int BP_UPPER = 5;
	localparam int BP_CFG = 4;
	// System configuration: bit that maps the EEPROM in.
	localparam int CFG_PRESENT = 0;

	// ----------------------------------------------------------------
	// Reset values, geometry and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] EEP_EEPROM_BLOCK_PROTECT_RST = 8'hff;
	localparam logic [7:0] EEP_ZERO_RST = 8'h00;
	localparam logic [7:0] EEP_CFG_RST = 8'hff;
	localparam logic [7:0] EEP_ERASED = 8'hff;
	localparam logic [3:0] EEP_MAP_LOW = 4'h0;
	localparam int EEP_BYTES = 640;
	localparam logic [11:0] EEP_BASE_OFS = 12'hd80;
	localparam logic [11:0] EEP_REG_F80 = 12'hf80;
	localparam logic [11:0] EEP_REG_E60 = 12'he60;
	localparam logic [11:0] EEP_REG_DE0 = 12'hde0;
	localparam logic [11:0] EEP_REG_DA0 = 12'hda0;
	localparam logic [6:0] EEP_BP_WINDOW = 7'h40;

	typedef enum logic [1:0] {
		EXT_BULK = 2'b00,
		EXT_ROW  = 2'b01,
		EXT_BYTE = 2'b10
	} eep_ext_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} eep_apb_req_s;

	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic [7:0]  wdata;
	} eep_cpu_req_s;

	typedef struct packed {
		logic        prog;
		logic        erase;
		eep_ext_e    ext;
		logic        cfg;
		logic [9:0]  idx;
		logic [7:0]  data;
	} eep_op_s;

	typedef struct packed {
		logic        latch;
		logic        hv_on;
		logic        user_off;
		logic [11:0] cell_addr;
	} eep_eprom_s;

endpackage

// File: rtl/eep_array.sv
module eep_array #(
	parameter int BYTES = 640
) (
	input  wire logic           clk,
	input  eep_pkg::eep_op_s    op,
	input  wire logic [9:0]     rd_idx,
	output logic [7:0]          rd_data,
	output logic [7:0]          cfg_data
);
	import eep_pkg::*;

	// ----------------------------------------------------------------
	// Nonvolatile cells
	// ----------------------------------------------------------------
	// No reset here on purpose: the cells must survive a reset so that
	// the configuration latches can be reloaded from them.
	logic [7:0] mem [BYTES];
	logic [7:0] cfg_cell;

	genvar g;
	generate
		for (g = 0; g < BYTES; g++) begin : g_cell
			localparam logic [9:0] IDX = 10'(g);
			logic hit_erase;
			assign hit_erase = op.erase && !op.cfg &&
				(op.ext == EXT_BULK ||
				 (op.ext == EXT_ROW && op.idx[9:4] == IDX[9:4]) ||
				 (op.ext == EXT_BYTE && op.idx == IDX));
			always_ff @(posedge clk) begin
				if (hit_erase) begin
					mem[g] <= EEP_ERASED;
				end else if (op.prog && !op.cfg && op.idx == IDX) begin
					// Programming can only pull bits to zero.
					mem[g] <= mem[g] & op.data;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (op.erase && op.cfg) begin
			cfg_cell <= EEP_ERASED;
		end else if (op.prog && op.cfg) begin
			cfg_cell <= cfg_cell & op.data;
		end
	end

	assign rd_data = (int'(rd_idx) < BYTES) ? mem[rd_idx] : EEP_ERASED;
	assign cfg_data = cfg_cell;

endmodule

// File: verif/eeprom_prog_erase_protect_test.sv
module eeprom_prog_erase_protect_test;
	timeunit 1ns;
	timeprecision 1ns;
	import eep_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic         clk;
	logic         sys_rst;
	logic         special_mode_flag;
	logic         low_supply_det;
	eep_apb_req_s apb;
	logic         pready;
	logic [31:0]  prdata;
	logic         pslverr;
	eep_cpu_req_s cpu;
	logic         cpu_sel;
	logic [7:0]   cpu_rdata;
	logic         eeprom_hv_on;
	eep_eprom_s   eprom;
	logic [7:0]   config_out;
	logic         rd_req;
	logic         rd_req_d;
	logic [32:0]  qa[$];
	logic [7:0]   qc[$];
	logic [7:0]   mem [0:639];
	logic [9:0]   ix [0:3];
	logic [7:0]   d;
	int           n_errors;
	int           checks;
	integer       seed;

	eep_ctrl eep_ctrl_inst (
		.clk               (clk),
		.sys_rst           (sys_rst),
		.special_mode_flag (special_mode_flag),
		.low_supply_det    (low_supply_det),
		.apb               (apb),
		.pready            (pready),
		.prdata            (prdata),
		.pslverr           (pslverr),
		.cpu               (cpu),
		.cpu_sel           (cpu_sel),
		.cpu_rdata         (cpu_rdata),
		.eeprom_hv_on      (eeprom_hv_on),
		.eprom             (eprom),
		.config_out        (config_out)
	);

	// The bench clock is 20 MHz, far above 1 MHz.
	always #25 clk = ~clk;

	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic fail(input string msg);
		n_errors++;
		$display("BAD %0t %s", $time, msg);
	endtask

	task automatic cmp_word(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) fail($sformatf("apb read %h expected %h", got, exp));
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
	endtask

	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Result monitor
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		rd_req_d <= rd_req;
	end

	always @(negedge clk) begin
		if (apb.psel === 1'b1 && apb.penable === 1'b1 && pready === 1'b1 && apb.pwrite === 1'b0) begin
			if (qa.size() == 0) fail("unexpected apb read");
			else cmp_word({pslverr, prdata}, qa.pop_front());
		end
		if (rd_req_d === 1'b1) begin
			if (qc.size() == 0) fail("unexpected cpu read");
			else cmp_byte(cpu_rdata, qc.pop_front());
		end
	end

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	function automatic logic [15:0] ea(input logic [9:0] i);
		return 16'h3d80 + {6'h00, i};
	endfunction

	task automatic apb_xfer(input logic wr_n, input logic [7:0] idx, input logic [7:0] wd,
			input logic [32:0] exp);
		int n;
		@(posedge clk);
		apb.psel <= 1'b1;
		apb.penable <= 1'b0;
		apb.pwrite <= wr_n;
		apb.paddr <= {2'b00, idx, 2'b00};
		apb.pwdata <= {24'h000000, wd};
		if (!wr_n) qa.push_back(exp);
		@(posedge clk);
		apb.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) fail("no pready");
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		apb_xfer(1'b1, idx, v, 33'h0);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] v);
		apb_xfer(1'b0, idx, 8'h00, {25'h0, v});
	endtask

	task automatic cpu_wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		cpu.addr <= a;
		cpu.wdata <= v;
		cpu.wr <= 1'b1;
		@(posedge clk);
		cpu.wr <= 1'b0;
	endtask

	task automatic cpu_rd(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		cpu.addr <= a;
		rd_req <= 1'b1;
		qc.push_back(v);
		@(posedge clk);
		rd_req <= 1'b0;
	endtask

	// Voltage is held for a few cycles only: the block has no pulse timer.
	task automatic hv_op(input logic [7:0] m, input logic [15:0] a, input logic [7:0] v,
			input bit chk);
		wr(EEP_IDX_EEPROM_CTL, m);
		cpu_wr(a, v);
		wr(EEP_IDX_EEPROM_CTL, m | 8'h01);
		@(negedge clk);
		if (chk) cmp_bit(eeprom_hv_on, 1'b1);
		cmp_bit(cpu_sel, 1'b0);
		repeat (8) @(posedge clk);
		wr(EEP_IDX_EEPROM_CTL, m);
		@(negedge clk);
		cmp_bit(eeprom_hv_on, 1'b0);
		wr(EEP_IDX_EEPROM_CTL, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h6edda642;
		clk = 1'b0;
		sys_rst = 1'b1;
		special_mode_flag = 1'b0;
		low_supply_det = 1'b0;
		apb = '0;
		cpu = '0;
		rd_req = 1'b0;
		n_errors = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(EEP_IDX_BLOCK_PROT, 8'hff);
		wr(EEP_IDX_BLOCK_PROT, 8'h00);
		rd(EEP_IDX_BLOCK_PROT, 8'h00);
		wr(EEP_IDX_BLOCK_PROT, 8'h01);
		wr(EEP_IDX_BLOCK_PROT, 8'h00);
		rd(EEP_IDX_BLOCK_PROT, 8'h01);
		rd(EEP_IDX_MAP_POS, 8'h00);
		rd(EEP_IDX_EEPROM_CTL, 8'h00);
		wr(EEP_IDX_MAP_POS, 8'h3f);
		rd(EEP_IDX_MAP_POS, 8'h30);
		wr(EEP_IDX_MAP_POS, 8'h50);
		rd(EEP_IDX_MAP_POS, 8'h30);
		apb_xfer(1'b0, 8'h01, 8'h00, {1'b1, 32'h0});
		special_mode_flag <= 1'b1;
		wr(EEP_IDX_SYS_CFG, 8'h0b);
		rd(EEP_IDX_SYS_CFG, 8'hfb);
		cmp_byte(config_out, 8'hfb);
		wr(EEP_IDX_EPROM_CTL, 8'h18);
		rd(EEP_IDX_EPROM_CTL, 8'h18);
		cmp_bit(eprom.user_off, 1'b1);
		cpu.addr <= 16'h0abf;
		@(posedge clk);
		@(negedge clk);
		cmp_word({21'h0, eprom.cell_addr}, 33'h0aa0);
		@(posedge clk);
		special_mode_flag <= 1'b0;
		rd(EEP_IDX_EPROM_CTL, 8'h00);
		special_mode_flag <= 1'b1;
		wr(EEP_IDX_EPROM_CTL, 8'h00);
		special_mode_flag <= 1'b0;
		wr(EEP_IDX_EPROM_CTL, 8'h01);
		rd(EEP_IDX_EPROM_CTL, 8'h00);
		wr(EEP_IDX_EPROM_CTL, 8'h20);
		@(negedge clk);
		cmp_bit(eprom.latch, 1'b1);
		wr(EEP_IDX_EPROM_CTL, 8'h21);
		rd(EEP_IDX_EPROM_CTL, 8'h21);
		cmp_bit(eprom.hv_on, 1'b1);
		wr(EEP_IDX_EPROM_CTL, 8'h00);
		wr(EEP_IDX_EPROM_CTL, 8'h00);
		hv_op(8'h06, ea(10'h080), 8'h00, 1'b1);
		for (int i = 0; i < 640; i++) mem[i] = 8'hff;
		cpu_rd(ea(10'h000), 8'hff);
		cpu_rd(ea(10'h27f), 8'hff);
		cpu_rd(16'h0d80, 8'h00);
		for (int k = 0; k < 4; k++) begin
			ix[k] = 10'h0a0 + 10'($unsigned($random(seed)) % 480);
			d = 8'($random(seed));
			hv_op(8'h02, ea(ix[k]), d, 1'b1);
			mem[ix[k]] = mem[ix[k]] & d;
			cpu_rd(ea(ix[k]), mem[ix[k]]);
		end
		hv_op(8'h02, ea(10'h005), 8'h00, 1'b0);
		cpu_rd(ea(10'h005), 8'hff);
		cpu_wr(ea(10'h0c0), 8'h00);
		cpu_rd(ea(10'h0c0), mem[10'h0c0]);
		hv_op(8'h16, ea(ix[3]), 8'h00, 1'b1);
		mem[ix[3]] = 8'hff;
		cpu_rd(ea(ix[3]), 8'hff);
		hv_op(8'h0e, ea(ix[0]), 8'h00, 1'b1);
		for (int i = 0; i < 16; i++) mem[{ix[0][9:4], 4'h0} + i] = 8'hff;
		cpu_rd(ea(ix[0]), 8'hff);
		cpu_rd(ea(ix[1]), mem[ix[1]]);
		hv_op(8'h02, ea(10'h180), 8'h3c, 1'b1);
		mem[10'h180] = mem[10'h180] & 8'h3c;
		wr(EEP_IDX_BLOCK_PROT, 8'h81);
		hv_op(8'h06, ea(10'h180), 8'h00, 1'b0);
		hv_op(8'h0e, ea(10'h180), 8'h00, 1'b0);
		cpu_rd(ea(10'h180), mem[10'h180]);
		wr(EEP_IDX_BLOCK_PROT, 8'hc1);
		low_supply_det <= 1'b1;
		repeat (4) @(posedge clk);
		rd(EEP_IDX_EEPROM_CTL, 8'h20);
		hv_op(8'h02, ea(10'h190), 8'h00, 1'b0);
		cpu_rd(ea(10'h190), mem[10'h190]);
		low_supply_det <= 1'b0;
		repeat (4) @(posedge clk);
		rd(EEP_IDX_EEPROM_CTL, 8'h00);
		wr(EEP_IDX_EEPROM_CTL, 8'h06);
		wr(EEP_IDX_SYS_CFG, 8'h00);
		wr(EEP_IDX_EEPROM_CTL, 8'h07);
		repeat (8) @(posedge clk);
		wr(EEP_IDX_EEPROM_CTL, 8'h00);
		wr(EEP_IDX_EEPROM_CTL, 8'h02);
		wr(EEP_IDX_SYS_CFG, 8'h05);
		wr(EEP_IDX_EEPROM_CTL, 8'h03);
		repeat (8) @(posedge clk);
		wr(EEP_IDX_EEPROM_CTL, 8'h00);
		rd(EEP_IDX_SYS_CFG, 8'hfb);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(EEP_IDX_SYS_CFG, 8'hf5);
		cmp_byte(config_out, 8'hf5);
		repeat (2) @(posedge clk);
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		stop_test();
	end
endmodule
